// ==== src/tx_timeout_test_defines.svh ====
// offsets, field positions, reset values and timing counts of the timeout test block
`ifndef TX_TIMEOUT_TEST_DEFINES_SVH
`define TX_TIMEOUT_TEST_DEFINES_SVH

// register word address on the host port
`define MASTER_CONFIG_TWO_ADDR   8'h4e
// field positions inside master_config_two
`define TRIGGER_BIT              15
`define PENDING_BIT              14
`define PART_ID_MSB              13
`define PART_ID_LSB              12
`define REV_ID_MSB               11
`define REV_ID_LSB               8
// identification codes, values arbitrary
`define PART_ID_VALUE            2'h2
`define REV_ID_VALUE             4'h3
// bus numbering and the pending interrupt bit each one raises
`define BUS_A                    0
`define BUS_B                    1
`define LOOPBACK_FAIL_A_BIT      12
`define LOOPBACK_FAIL_B_BIT      11
// timing: figures in their own units, counts derived
`define CLK_PERIOD_NS            8
`define TIMEOUT_NS               663000
`define TIMEOUT_CYCLES           (`TIMEOUT_NS / `CLK_PERIOD_NS)
`define TEST_BURST_NS            700000
`define TEST_BURST_CYCLES        (`TEST_BURST_NS / `CLK_PERIOD_NS)
`define TEST_BURST_WORDS         35
`define WDOG_CNT_W               17

`endif

// ==== src/tx_timeout_test_pkg.sv ====
// types shared by the timeout test block and its watchdogs
`include "tx_timeout_test_defines.svh"

package tx_timeout_test_pkg;

    // test sequencer, one-hot
    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0001,
        ST_ARMED   = 4'b0010,
        ST_PENDING = 4'b0100,
        ST_RUNNING = 4'b1000
    } test_state_t;

    // state of one transmitter watchdog
    typedef struct packed {
        logic [`WDOG_CNT_W-1:0] count;
        logic                   cut;
    } wdog_state_t;

    // state of the top block
    typedef struct packed {
        test_state_t state;
        logic        test_bus;
        logic [1:0]  prev_request;
        logic [1:0]  prev_cut;
        logic [1:0]  tx_enable;
        logic [1:0]  loopback_fail;
        logic        test_burst;
        logic [15:0] rdata;
        logic        rvalid;
    } top_state_t;

endpackage

// ==== src/wdog_if.sv ====
// link between the test block and one transmitter watchdog
`timescale 1ns/100ps
`default_nettype none

interface wdog_if;
    logic request;   // transmitter wants to send
    logic cut;       // watchdog has expired, hold the transmitter off

    modport wdog (input request, output cut);
    modport user (output request, input cut);
endinterface

`default_nettype wire

// ==== src/tx_watchdog.sv ====
// transmit watchdog for one bus, counting only while the request is up and cleared when it drops
`include "tx_timeout_test_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module tx_watchdog
    import tx_timeout_test_pkg::*;
#(
    parameter int LIMIT = `TIMEOUT_CYCLES
)(
    input  wire logic core_clk,
    input  wire logic rst_n,
    wdog_if.wdog      link
);

    wdog_state_t cur;    // registered state
    wdog_state_t next_s; // next state

    // count every requesting cycle; expire one cycle before the limit so the
    // registered enable in the top block is high for exactly LIMIT cycles
    always_comb
    begin
        next_s = cur;
        if (!link.request)
        begin
            // transmission over: rearm for the next one
            next_s.count = '0;
            next_s.cut   = 1'b0;
        end
        else
        begin
            if (cur.count != {`WDOG_CNT_W{1'b1}})
                next_s.count = cur.count + `WDOG_CNT_W'(1);
            if (cur.count >= `WDOG_CNT_W'(LIMIT - 1))
                next_s.cut = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            cur <= '0;
        else
            cur <= next_s;
    end

    assign link.cut = cur.cut;

    // cut holds for as long as the request stays up
    cut_holds_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        cur.cut && link.request |=> cur.cut)
        else $error("watchdog released while request still high");

endmodule

`default_nettype wire

// ==== src/tx_timeout_test.sv ====
// transmitter timeout protection test: arming sequence, pending flag, watchdogs
//
// Notes on behaviour
// - watchdog cuts each bus transmitter after 663us
// - completed sequence with the test pin held sets the pending flag
// - pending test sends 35 incrementing words, 700us
// - cutoff during the test burst raises enabled loopback fail bit 12/11
// - trigger bit always reads zero, nothing clears on read
// - pending clears when the test transmission starts
// - part and revision identifiers read after reset
`include "tx_timeout_test_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module tx_timeout_test
    import tx_timeout_test_pkg::*;
#(
    parameter int WATCHDOG_CYCLES = `TIMEOUT_CYCLES
)(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        test_pin,
    input  wire logic        acc_valid,
    input  wire logic        acc_write,
    input  wire logic [7:0]  acc_addr,
    input  wire logic [15:0] acc_wdata,
    output var  logic [15:0] acc_rdata,
    output var  logic        acc_rvalid,
    input  wire logic [1:0]  tx_request,
    output var  logic [1:0]  tx_enable,
    input  wire logic [1:0]  loopback_int_enable,
    output var  logic [1:0]  loopback_fail,
    output var  logic        test_burst
);

    top_state_t cur;         // registered state
    top_state_t next_s;      // next state
    logic [1:0] cut;         // watchdog expiry per bus
    logic [1:0] tx_start;    // request rising edge per bus
    logic [1:0] cut_rise;    // watchdog expiry edge per bus
    logic       hit_reg;     // access addresses master_config_two
    logic       wr_trigger;  // write with the trigger bit set

    // address match, used by both the sequencer and the read path
    function automatic logic is_config(input logic [7:0] addr);
        return addr == `MASTER_CONFIG_TWO_ADDR;
    endfunction

    // one watchdog per transmitter
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : gen_wdog
            wdog_if bus_link ();
            assign bus_link.request = tx_request[g];
            assign cut[g]           = bus_link.cut;
            tx_watchdog #(
                .LIMIT (WATCHDOG_CYCLES)
            ) u_wdog (
                .core_clk (core_clk),
                .rst_n    (rst_n),
                .link     (bus_link)
            );
        end
    endgenerate

    assign tx_start   = tx_request & ~cur.prev_request;
    assign cut_rise   = cut & ~cur.prev_cut;
    assign hit_reg    = acc_valid && is_config(acc_addr);
    assign wr_trigger = hit_reg && acc_write && acc_wdata[`TRIGGER_BIT];

    // sequencer, transmit gating and register read path
    always_comb
    begin
        next_s               = cur;
        next_s.prev_request  = tx_request;
        next_s.prev_cut      = cut;
        next_s.loopback_fail = 2'b00;
        next_s.rvalid        = 1'b0;
        // enable drops once the watchdog expires
        next_s.tx_enable     = tx_request & ~cut;

        case (cur.state)
            ST_IDLE:
            begin
                // arm only with the test pin held
                if (wr_trigger && test_pin)
                    next_s.state = ST_ARMED;
            end
            ST_ARMED:
            begin
                // the very next access of any kind decides
                if (acc_valid)
                begin
                    if (hit_reg && acc_write && !acc_wdata[`TRIGGER_BIT])
                        next_s.state = ST_PENDING;
                    else
                        next_s.state = ST_IDLE;
                end
            end
            ST_PENDING:
            begin
                if (tx_start != 2'b00)
                begin
                    next_s.state      = ST_RUNNING;
                    next_s.test_bus   = tx_start[`BUS_A] ? 1'b0 : 1'b1;
                    next_s.test_burst = 1'b1;
                end
            end
            ST_RUNNING:
            begin
                // cutoff raises the enabled fail bit
                if (cut_rise[cur.test_bus])
                begin
                    next_s.loopback_fail[cur.test_bus] = loopback_int_enable[cur.test_bus];
                    next_s.test_burst                  = 1'b0;
                    next_s.state                       = ST_IDLE;
                end
                else if (!tx_request[cur.test_bus])
                begin
                    // burst ended by itself: protection failed, nothing raised
                    next_s.test_burst = 1'b0;
                    next_s.state      = ST_IDLE;
                end
            end
            default:
            begin
                next_s.state      = ST_IDLE;
                next_s.test_burst = 1'b0;
            end
        endcase

        // read path; fields outside this block read zero
        if (acc_valid && !acc_write)
        begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = 16'h0000;
            if (is_config(acc_addr))
            begin
                next_s.rdata[`TRIGGER_BIT] = 1'b0;
                next_s.rdata[`PENDING_BIT] = (cur.state == ST_PENDING);
                next_s.rdata[`PART_ID_MSB:`PART_ID_LSB] = `PART_ID_VALUE;
                next_s.rdata[`REV_ID_MSB:`REV_ID_LSB]   = `REV_ID_VALUE;
            end
        end
    end

    // single state register
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur       <= '0;
            cur.state <= ST_IDLE;
        end
        else
            cur <= next_s;
    end

    assign acc_rdata     = cur.rdata;
    assign acc_rvalid    = cur.rvalid;
    assign tx_enable     = cur.tx_enable;
    assign loopback_fail = cur.loopback_fail;
    assign test_burst    = cur.test_burst;

    // ---- checks ----
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // helper: consecutive enabled cycles per bus A
    logic [`WDOG_CNT_W:0] run_a;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            run_a <= '0;
        else if (tx_enable[`BUS_A])
            run_a <= run_a + (`WDOG_CNT_W+1)'(1);
        else
            run_a <= '0;
    end

    tx_length_a: assert property (run_a <= (`WDOG_CNT_W+1)'(WATCHDOG_CYCLES))
        else $error("bus A transmitted past the timeout");

    pending_set_a: assert property (cur.state == ST_ARMED && hit_reg && acc_write
        && !acc_wdata[`TRIGGER_BIT] |=> cur.state == ST_PENDING)
        else $error("pending not set after arming sequence");

    // burst only follows a pending test
    burst_cause_a: assert property ($rose(test_burst)
        |-> $past(cur.state) == ST_PENDING)
        else $error("test burst without pending test");

    // cutoff during burst gives fail pulse
    fail_pulse_a: assert property (cur.state == ST_RUNNING && cut_rise[`BUS_A] && !cur.test_bus
        && loopback_int_enable[`BUS_A] |=> loopback_fail[`BUS_A] ##1 !loopback_fail[`BUS_A])
        else $error("bus A loopback fail not pulsed");

    trigger_read_a: assert property (acc_rvalid |-> !acc_rdata[`TRIGGER_BIT])
        else $error("trigger bit read back as one");

    pending_clear_a: assert property (cur.state == ST_PENDING && tx_start != 2'b00
        |=> cur.state == ST_RUNNING && test_burst)
        else $error("pending not cleared on transmission start");

    id_read_a: assert property (acc_valid && !acc_write && is_config(acc_addr)
        |=> acc_rvalid && acc_rdata[`REV_ID_MSB:`REV_ID_LSB] == `REV_ID_VALUE
            && acc_rdata[`PART_ID_MSB:`PART_ID_LSB] == `PART_ID_VALUE)
        else $error("identification fields wrong");

    no_pin_arm_a: assert property (cur.state == ST_IDLE && wr_trigger && !test_pin
        |=> cur.state == ST_IDLE)
        else $error("armed without test pin");

    bad_follow_a: assert property (cur.state == ST_ARMED && acc_valid
        && !(hit_reg && acc_write && !acc_wdata[`TRIGGER_BIT]) |=> cur.state == ST_IDLE)
        else $error("arm kept after wrong access");

    arm_seen_c:    cover property (cur.state == ST_ARMED ##[1:20] cur.state == ST_PENDING);
    burst_seen_c:  cover property ($rose(test_burst));
    fail_seen_c:   cover property (loopback_fail != 2'b00);
    cut_seen_c:    cover property ($fell(tx_enable[`BUS_B]) && tx_request[`BUS_B]);

endmodule

`default_nettype wire

// ==== sim/host_model.sv ====
// host model: drives the register strobe port and the test pin
`include "tx_timeout_test_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module host_model
(
    input  wire logic        core_clk,
    output var  logic        test_pin,
    output var  logic        acc_valid,
    output var  logic        acc_write,
    output var  logic [7:0]  acc_addr,
    output var  logic [15:0] acc_wdata
);
    // idle values from time zero
    initial
    begin
        test_pin  = 1'b0;
        acc_valid = 1'b0;
        acc_write = 1'b0;
        acc_addr  = 8'h00;
        acc_wdata = 16'h0000;
    end

    // one access, strobe held across exactly one edge
    task automatic access(input logic wr, input logic [7:0] addr, input logic [15:0] data);
        @(posedge core_clk);
        #1;
        acc_valid = 1'b1;
        acc_write = wr;
        acc_addr  = addr;
        acc_wdata = data;
        @(posedge core_clk);
        #1;
        acc_valid = 1'b0;
        // released data must not look like the last word
        acc_wdata = ~data;
    endtask

    // arming sequence; a broken one goes elsewhere on its second access
    task automatic arm(input logic with_pin, input logic complete, input logic [13:0] junk);
        @(posedge core_clk);
        #1;
        test_pin = with_pin;
        access(1'b1, `MASTER_CONFIG_TWO_ADDR, {2'b10, junk});
        test_pin = 1'b0;
        access(1'b1, complete ? `MASTER_CONFIG_TWO_ADDR : 8'h4f, {2'b00, junk});
    endtask
endmodule

`default_nettype wire

// ==== sim/tx_timeout_test_tb_top.sv ====
// self-checking bench for the transmitter timeout test block
`include "tx_timeout_test_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module tx_timeout_test_tb_top;
    import tx_timeout_test_pkg::*;

    localparam int          WD        = 20;   // shortened watchdog span
    localparam logic [15:0] IDLE_WORD = {2'b00, `PART_ID_VALUE, `REV_ID_VALUE, 8'h00};
    localparam logic [7:0]  CFG       = `MASTER_CONFIG_TWO_ADDR;

    logic        core_clk;
    logic        rst_n;
    logic        test_pin;
    logic        acc_valid;
    logic        acc_write;
    logic [7:0]  acc_addr;
    logic [15:0] acc_wdata;
    logic [15:0] acc_rdata;
    logic        acc_rvalid;
    logic [1:0]  tx_request;
    logic [1:0]  tx_enable;
    logic [1:0]  loopback_int_enable;
    logic [1:0]  loopback_fail;
    logic        test_burst;
    int          fails;
    int          tests_run;
    int          en_cnt [2];       // enabled cycles seen per bus
    int          fail_cnt [2];     // fail pulses seen per bus
    logic [15:0] exp_q [$];        // expected read words, oldest first

    tx_timeout_test #(.WATCHDOG_CYCLES(WD)) u_tx_timeout_test (
        .core_clk(core_clk), .rst_n(rst_n), .test_pin(test_pin), .acc_valid(acc_valid),
        .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
        .acc_rvalid(acc_rvalid), .tx_request(tx_request), .tx_enable(tx_enable),
        .loopback_int_enable(loopback_int_enable), .loopback_fail(loopback_fail), .test_burst(test_burst));

    host_model u_host_model (
        .core_clk(core_clk), .test_pin(test_pin), .acc_valid(acc_valid), .acc_write(acc_write),
        .acc_addr(acc_addr), .acc_wdata(acc_wdata));

    // 125 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // one compare for every kind of value
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // read: note the expectation first, the monitor pairs it later
    task automatic rd(input logic [7:0] addr, input logic [15:0] exp);
        exp_q.push_back(exp);
        u_host_model.access(1'b0, addr, 16'h0000);
    endtask

    // monitor: old values at the edge are the settled ones
    always @(posedge core_clk)
    begin
        if (acc_rvalid === 1'b1)
        begin
            if (exp_q.size() > 0)
                chk("read data", exp_q.pop_front(), acc_rdata);
            else
                chk("unexpected read", 16'h0000, 16'hffff);
        end
        for (int b = 0; b < 2; b++)
        begin
            en_cnt[b]   += int'(tx_enable[b] === 1'b1);
            fail_cnt[b] += int'(loopback_fail[b] === 1'b1);
        end
    end

    // one transmission; request stays up for hold+5 edges
    task automatic run(input int bus, input logic [1:0] ien, input int hold, input logic is_test);
        @(posedge core_clk);
        #1;
        loopback_int_enable = ien;
        en_cnt              = '{0, 0};
        fail_cnt            = '{0, 0};
        tx_request[bus]     = 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        chk("test burst", {15'h0, is_test}, {15'h0, test_burst});
        rd(CFG, IDLE_WORD);
        repeat (hold) @(posedge core_clk);
        #1;
        tx_request[bus] = 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        chk("enable cycles", 16'((hold + 5 > WD) ? WD : hold + 5), 16'(en_cnt[bus]));
        chk("fail pulses", 16'(is_test && hold + 5 > WD && ien[bus]), 16'(fail_cnt[bus]));
        chk("burst end", 16'h0000, {15'h0, test_burst});
        $display("test bus %0d hold %0d done", bus, hold);
    endtask

    // verdict in one place
    task automatic conclude();
        if (exp_q.size() != 0)
            fails++;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // hang guard, far beyond the few hundred cycles needed
    initial
    begin
        #40000;
        fails++;
        conclude();
    end

    // main sequence
    initial
    begin
        fails               = 0;
        tests_run           = 0;
        rst_n               = 1'b0;
        tx_request          = 2'b00;
        loopback_int_enable = 2'b00;
        void'($urandom(32'h51afadfd));
        repeat (16) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        rd(CFG, IDLE_WORD);
        rd(8'h4f, 16'h0000);
        $display("test reset values done");
        u_host_model.arm(1'b0, 1'b1, 14'($urandom));
        rd(CFG, IDLE_WORD);
        u_host_model.arm(1'b1, 1'b0, 14'($urandom));
        rd(CFG, IDLE_WORD);
        $display("test broken arming done");
        u_host_model.arm(1'b1, 1'b1, 14'($urandom));
        rd(CFG, IDLE_WORD | 16'h4000);
        run(`BUS_A, 2'b01, 40, 1'b1);
        u_host_model.arm(1'b1, 1'b1, 14'($urandom));
        run(`BUS_B, 2'b10, 40, 1'b1);
        u_host_model.arm(1'b1, 1'b1, 14'($urandom));
        run(`BUS_A, 2'b00, 40, 1'b1);
        run(`BUS_B, 2'($urandom), 40, 1'b0);
        u_host_model.arm(1'b1, 1'b1, 14'($urandom));
        run(`BUS_A, 2'($urandom), 1 + int'($urandom % 10), 1'b1);
        conclude();
    end
endmodule

`default_nettype wire
